/* mcp_pwm_unit.sv */
/*
  Motor control pwm unit: time base, three duty generators, fault override,
  update lockout, special event trigger with postscaler, APB register slave.
  Assumes fault_a_input is an asynchronous pin; sleep_mode and idle_mode come
  from core logic on pclk.
*/
// Implementation choices: the APB slave port and the register offsets.
// What this block does
// - three duty generators drive three high/low output pairs
// - low output of each pair is the inverse of its high output unless a fault forces the pair
// - time base, period and duty compares are sixteen bits wide
// - edge-aligned or centre-aligned waveforms chosen by time base mode
// - single pulse mode produces one period then stops the time base
// - up/down double mode also loads at the top turn for asymmetrical duty updates
// - asserted fault forces enabled pairs to their programmed levels
// - update_disable set blocks every duty and period buffer load
// - special event trigger pulses toward the A/D converter
// - special event fires when time_base_count equals event_compare_value
// - in up/down mode event_count_direction picks the counting phase
// - event_count_direction is ignored in other time base modes
// - event_postscale_select divides special events from 1:1 to 1:16
// - postscaler count clears on event_compare_value write and on reset
// - fault_a_input low during sleep raises a wake interrupt
// - idle_stop_select set halts the unit while idle lasts
`timescale 1ns/10ps
module mcp_pwm_unit (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              fault_a_input,
  input  wire logic              sleep_mode,
  input  wire logic              idle_mode,
  output mcp_pkg::mcp_pins_t     pwm_pins,
  output logic                   adc_trigger,
  output logic                   irq
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic                  pready_ff;
  logic                  pslverr_ff;
  logic [31:0]           prdata_ff;
  logic [31:0]           nxt_prdata;
  logic                  nxt_hit;
  logic                  tb_en_ff;
  mcp_pkg::mcp_mode_t    mode_ff;
  logic                  idle_stop_ff;
  logic [15:0]           per_buf_ff;
  logic [15:0]           per_act_ff;
  logic [15:0]           duty_buf_ff [0:2];
  logic [15:0]           duty_act_ff [0:2];
  logic [15:0]           sev_val_ff;
  logic                  sev_dir_ff;
  logic                  update_disable_ff;
  logic [3:0]            post_sel_ff;
  logic [2:0]            flt_en_ff;
  logic [5:0]            flt_lvl_ff;
  logic [15:0]           cnt_ff;
  mcp_pkg::mcp_tb_state_t st_ff;
  logic [3:0]            post_cnt_ff;
  logic                  trig_ff;
  logic [4:0]            sts_ff;
  logic [4:0]            ien_ff;
  logic                  irq_ff;
  logic                  flt_meta_ff;
  logic                  flt_sync_ff;
  mcp_pkg::mcp_pins_t    pins_ff;
  mcp_pkg::mcp_pins_t    nxt_pins;
  logic                  wr_go;
  logic                  rd_go;
  logic                  run;
  logic                  updn;
  logic                  at_top;
  logic                  top_evt;
  logic                  bot_evt;
  logic                  bnd;
  logic                  load;
  logic                  sev_hit;
  logic                  fault_act;
  logic [4:0]            sts_set;

  function automatic logic wr_at(input logic [11:0] ofs);
    wr_at = wr_go && (paddr == ofs);
  endfunction : wr_at

  assign pready      = pready_ff;
  assign pslverr     = pslverr_ff;
  assign prdata      = prdata_ff;
  assign pwm_pins    = pins_ff;
  assign adc_trigger = trig_ff;
  assign irq         = irq_ff;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  // one wait state: data is registered on the same edge that raises pready
  assign rd_go = psel && penable && !pready_ff;
  assign wr_go = psel && penable && pready_ff && pwrite;

  always_comb begin
    nxt_prdata = 32'h0;
    nxt_hit    = 1'b1;
    case (paddr)
      mcp_pkg::OFS_TB_CTRL:  nxt_prdata = {28'h0, idle_stop_ff, mode_ff, tb_en_ff};
      mcp_pkg::OFS_PER_BUF:  nxt_prdata = {16'h0, per_buf_ff};
      mcp_pkg::OFS_DUTY1:    nxt_prdata = {16'h0, duty_buf_ff[0]};
      mcp_pkg::OFS_DUTY2:    nxt_prdata = {16'h0, duty_buf_ff[1]};
      mcp_pkg::OFS_DUTY3:    nxt_prdata = {16'h0, duty_buf_ff[2]};
      mcp_pkg::OFS_SEV_CMP:  nxt_prdata = {15'h0, sev_dir_ff, sev_val_ff};
      mcp_pkg::OFS_OUT_CTL2: nxt_prdata = {18'h0, flt_lvl_ff, flt_en_ff, post_sel_ff, update_disable_ff};
      mcp_pkg::OFS_TB_COUNT: nxt_prdata = {14'h0, st_ff, cnt_ff};
      mcp_pkg::OFS_IRQ_STS:  nxt_prdata = {27'h0, sts_ff};
      mcp_pkg::OFS_IRQ_CLR:  nxt_prdata = 32'h0;
      mcp_pkg::OFS_IRQ_EN:   nxt_prdata = {27'h0, ien_ff};
      default:               nxt_hit    = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0;
    end else begin
      pready_ff  <= rd_go;
      pslverr_ff <= rd_go && !nxt_hit;
      if (rd_go) begin
        prdata_ff <= pwrite ? 32'h0 : nxt_prdata;
      end
    end
  end

  AST_APB_ONE_WAIT: assert property (rd_go |=> pready_ff ##1 !pready_ff)
    else $error("apb answer not one wait state");

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tb_en_ff     <= 1'b0;
      mode_ff      <= mcp_pkg::MODE_FREE;
      idle_stop_ff <= 1'b0;
    end else if (wr_at(mcp_pkg::OFS_TB_CTRL)) begin
      tb_en_ff     <= pwdata[mcp_pkg::TB_EN_BIT];
      mode_ff      <= mcp_pkg::mcp_mode_t'(pwdata[mcp_pkg::TB_MODE_LSB +: 2]);
      idle_stop_ff <= pwdata[mcp_pkg::TB_SIDL_BIT];
    end else if (st_ff == mcp_pkg::TB_DONE) begin
      tb_en_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_buf_ff     <= mcp_pkg::RST_PERIOD;
      duty_buf_ff[0] <= mcp_pkg::RST_DUTY;
      duty_buf_ff[1] <= mcp_pkg::RST_DUTY;
      duty_buf_ff[2] <= mcp_pkg::RST_DUTY;
      sev_val_ff     <= mcp_pkg::RST_SEV;
      sev_dir_ff     <= 1'b0;
      update_disable_ff        <= 1'b0;
      post_sel_ff    <= mcp_pkg::RST_POST;
      flt_en_ff      <= 3'h0;
      flt_lvl_ff     <= 6'h0;
    end else begin
      if (wr_at(mcp_pkg::OFS_PER_BUF)) per_buf_ff <= pwdata[15:0];
      if (wr_at(mcp_pkg::OFS_DUTY1)) duty_buf_ff[0] <= pwdata[15:0];
      if (wr_at(mcp_pkg::OFS_DUTY2)) duty_buf_ff[1] <= pwdata[15:0];
      if (wr_at(mcp_pkg::OFS_DUTY3)) duty_buf_ff[2] <= pwdata[15:0];
      if (wr_at(mcp_pkg::OFS_SEV_CMP)) begin
        sev_val_ff <= pwdata[15:0];
        sev_dir_ff <= pwdata[mcp_pkg::SEV_DIR_BIT];
      end
      if (wr_at(mcp_pkg::OFS_OUT_CTL2)) begin
        update_disable_ff     <= pwdata[mcp_pkg::OC2_UPDATE_DISABLE_BIT];
        post_sel_ff <= pwdata[mcp_pkg::OC2_POST_LSB +: 4];
        flt_en_ff   <= pwdata[mcp_pkg::OC2_FEN_LSB +: 3];
        flt_lvl_ff  <= pwdata[mcp_pkg::OC2_FLVL_LSB +: 6];
      end
    end
  end

  // ---------------------------------------------------------------
  // time base
  // ---------------------------------------------------------------
  assign run     = tb_en_ff && !sleep_mode && !(idle_mode && idle_stop_ff);
  assign updn    = mode_ff[1];
  // >= keeps the count bounded if a shorter period lands at a boundary
  assign at_top  = cnt_ff >= per_act_ff;
  assign top_evt = run && (st_ff == mcp_pkg::TB_UP) && at_top;
  assign bot_evt = run && (st_ff == mcp_pkg::TB_DOWN) && (cnt_ff == 16'h0);
  assign bnd     = (top_evt && (!updn || mode_ff == mcp_pkg::MODE_UPDN_DBL)) || bot_evt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff  <= mcp_pkg::TB_IDLE;
      cnt_ff <= 16'h0;
    end else if (!tb_en_ff) begin
      st_ff  <= mcp_pkg::TB_IDLE;
      cnt_ff <= 16'h0;
    end else if (run) begin
      case (st_ff)
        mcp_pkg::TB_IDLE: st_ff <= mcp_pkg::TB_UP;
        mcp_pkg::TB_UP: begin
          if (!at_top) begin
            cnt_ff <= cnt_ff + 16'h1;
          end else if (updn) begin
            st_ff  <= mcp_pkg::TB_DOWN;
            cnt_ff <= (cnt_ff == 16'h0) ? 16'h0 : cnt_ff - 16'h1;
          end else if (mode_ff == mcp_pkg::MODE_SINGLE) begin
            st_ff <= mcp_pkg::TB_DONE;
          end else begin
            cnt_ff <= 16'h0;
          end
        end
        mcp_pkg::TB_DOWN: begin
          if (cnt_ff == 16'h0) begin
            st_ff  <= mcp_pkg::TB_UP;
            cnt_ff <= 16'h1;
          end else begin
            cnt_ff <= cnt_ff - 16'h1;
          end
        end
        mcp_pkg::TB_DONE: st_ff <= mcp_pkg::TB_DONE;
        default:          st_ff <= mcp_pkg::TB_IDLE;
      endcase
    end
  end

  AST_IDLE_HALT: assert property (tb_en_ff && idle_mode && idle_stop_ff |=> $stable(cnt_ff))
    else $error("time base moved while halted in idle");
  AST_SINGLE_STOP: assert property (st_ff == mcp_pkg::TB_DONE |=> !tb_en_ff || $past(wr_go))
    else $error("single pulse did not stop the time base");

  // ---------------------------------------------------------------
  // buffered period and duty
  // ---------------------------------------------------------------
  // while stopped there is no period to tear, so loads pass at once
  assign load = !update_disable_ff && (bnd || !tb_en_ff);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_act_ff     <= mcp_pkg::RST_PERIOD;
      duty_act_ff[0] <= mcp_pkg::RST_DUTY;
      duty_act_ff[1] <= mcp_pkg::RST_DUTY;
      duty_act_ff[2] <= mcp_pkg::RST_DUTY;
    end else if (load) begin
      per_act_ff     <= per_buf_ff;
      duty_act_ff[0] <= duty_buf_ff[0];
      duty_act_ff[1] <= duty_buf_ff[1];
      duty_act_ff[2] <= duty_buf_ff[2];
    end
  end

  AST_UPDATE_DISABLE_HOLD: assert property (update_disable_ff |=> $stable(per_act_ff) && $stable(duty_act_ff[0]))
    else $error("buffer loaded while update lockout set");
  AST_MID_PERIOD: assert property (tb_en_ff && !bnd |=> $stable(per_act_ff))
    else $error("period changed in mid period");

  // ---------------------------------------------------------------
  // fault input and outputs
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flt_meta_ff <= 1'b1;
      flt_sync_ff <= 1'b1;
    end else begin
      flt_meta_ff <= fault_a_input;
      flt_sync_ff <= flt_meta_ff;
    end
  end

  assign fault_act = !flt_sync_ff;

  always_comb begin
    nxt_pins = '0;
    for (int p = 0; p < 3; p++) begin
      nxt_pins.high_output[p] = (st_ff == mcp_pkg::TB_UP || st_ff == mcp_pkg::TB_DOWN)
                                && (cnt_ff < duty_act_ff[p]);
      nxt_pins.low_output[p]  = !nxt_pins.high_output[p];
      if (fault_act && flt_en_ff[p]) begin
        nxt_pins.high_output[p] = flt_lvl_ff[p];
        nxt_pins.low_output[p]  = flt_lvl_ff[p+3];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_ff <= '{high_output: 3'h0, low_output: 3'h7};
    end else begin
      pins_ff <= nxt_pins;
    end
  end

  AST_COMPLEMENT: assert property (!$past(fault_act) |-> pwm_pins.low_output == ~pwm_pins.high_output)
    else $error("low output not complement of high output");
  AST_FAULT_FORCE: assert property (fault_act && flt_en_ff[0] |=> pwm_pins.high_output[0] == $past(flt_lvl_ff[0])
                                    && pwm_pins.low_output[0] == $past(flt_lvl_ff[3]))
    else $error("fault did not force pair one");

  // ---------------------------------------------------------------
  // special event trigger
  // ---------------------------------------------------------------
  assign sev_hit = run && (st_ff == mcp_pkg::TB_UP || st_ff == mcp_pkg::TB_DOWN)
                   && (cnt_ff == sev_val_ff)
                   && (!updn || (sev_dir_ff ? st_ff == mcp_pkg::TB_DOWN : st_ff == mcp_pkg::TB_UP));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      post_cnt_ff <= 4'h0;
      trig_ff     <= 1'b0;
    end else if (wr_at(mcp_pkg::OFS_SEV_CMP)) begin
      post_cnt_ff <= 4'h0;
      trig_ff     <= 1'b0;
    end else if (sev_hit && post_cnt_ff == post_sel_ff) begin
      post_cnt_ff <= 4'h0;
      trig_ff     <= 1'b1;
    end else begin
      post_cnt_ff <= sev_hit ? post_cnt_ff + 4'h1 : post_cnt_ff;
      trig_ff     <= 1'b0;
    end
  end

  AST_SEV_CAUSE: assert property (adc_trigger |-> $past(sev_hit) && $past(post_cnt_ff) == $past(post_sel_ff))
    else $error("trigger without compare match at ratio");
  AST_SEV_DIR: assert property (adc_trigger && $past(updn) |-> $past(st_ff) ==
                                ($past(sev_dir_ff) ? mcp_pkg::TB_DOWN : mcp_pkg::TB_UP))
    else $error("trigger in wrong counting phase");
  AST_POST_CLR: assert property (wr_go && paddr == mcp_pkg::OFS_SEV_CMP |=> post_cnt_ff == 4'h0 && !adc_trigger)
    else $error("postscaler not cleared by compare write");
  AST_TRIG_RESTART: assert property (adc_trigger |-> post_cnt_ff == 4'h0)
    else $error("postscaler not restarted after trigger");

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------
  always_comb begin
    sts_set            = '0;
    sts_set[mcp_pkg::IRQ_TOP]   = top_evt;
    sts_set[mcp_pkg::IRQ_BOT]   = bot_evt;
    sts_set[mcp_pkg::IRQ_FAULT] = fault_act && (|flt_en_ff);
    sts_set[mcp_pkg::IRQ_SEV]   = trig_ff;
    sts_set[mcp_pkg::IRQ_WAKE]  = sleep_mode && fault_act;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_ff <= '0;
      ien_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      // set beats a same-cycle clear so no event is lost
      sts_ff <= (sts_ff & ~(wr_at(mcp_pkg::OFS_IRQ_CLR) ? pwdata[4:0] : 5'h0)) | sts_set;
      if (wr_at(mcp_pkg::OFS_IRQ_EN)) ien_ff <= pwdata[4:0];
      irq_ff <= |(sts_ff & ien_ff);
    end
  end

  AST_WAKE: assert property (sleep_mode && fault_act |=> sts_ff[mcp_pkg::IRQ_WAKE])
    else $error("fault in sleep did not raise wake status");
  AST_IRQ_LEVEL: assert property (|(sts_ff & ien_ff) |=> irq)
    else $error("enabled status did not raise irq");

  COV_TRIGGER:   cover property (adc_trigger);
  COV_UPDN_LOAD: cover property (bot_evt && load);
  COV_FAULT:     cover property (fault_act && flt_en_ff != 3'h0 ##1 fault_act);
  COV_WAKE_IRQ:  cover property (sts_ff[mcp_pkg::IRQ_WAKE] ##1 irq);

endmodule : mcp_pwm_unit

/* mcp_pkg.sv */
/*
  Shared constants, types and the register map of the motor control pwm unit.
  Assumes a 32-bit APB master and byte addresses on paddr.
*/
package mcp_pkg;

  // ---------------------------------------------------------------
  // register map (byte offsets)
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_TB_CTRL  = 12'h000;
  localparam logic [11:0] OFS_PER_BUF  = 12'h004;
  localparam logic [11:0] OFS_DUTY1    = 12'h008;
  localparam logic [11:0] OFS_DUTY2    = 12'h00c;
  localparam logic [11:0] OFS_DUTY3    = 12'h010;
  localparam logic [11:0] OFS_SEV_CMP  = 12'h014;
  localparam logic [11:0] OFS_OUT_CTL2 = 12'h018;
  localparam logic [11:0] OFS_TB_COUNT = 12'h01c;
  localparam logic [11:0] OFS_IRQ_STS  = 12'h020;
  localparam logic [11:0] OFS_IRQ_CLR  = 12'h024;
  localparam logic [11:0] OFS_IRQ_EN   = 12'h028;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned TB_EN_BIT     = 0;
  localparam int unsigned TB_MODE_LSB   = 1;
  localparam int unsigned TB_SIDL_BIT   = 3;
  localparam int unsigned SEV_DIR_BIT   = 16;
  localparam int unsigned OC2_UPDATE_DISABLE_BIT  = 0;
  localparam int unsigned OC2_POST_LSB  = 1;
  localparam int unsigned OC2_FEN_LSB   = 5;
  localparam int unsigned OC2_FLVL_LSB  = 8;
  localparam int unsigned CNT_ST_LSB    = 16;

  localparam int unsigned IRQ_TOP   = 0;
  localparam int unsigned IRQ_BOT   = 1;
  localparam int unsigned IRQ_FAULT = 2;
  localparam int unsigned IRQ_SEV   = 3;
  localparam int unsigned IRQ_WAKE  = 4;
  localparam int unsigned IRQ_W     = 5;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_PERIOD = 16'hffff;
  localparam logic [15:0] RST_DUTY   = 16'h0000;
  localparam logic [15:0] RST_SEV    = 16'h0000;
  localparam logic [3:0]  RST_POST   = 4'h0;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_FREE     = 2'h0,
    MODE_SINGLE   = 2'h1,
    MODE_UPDN     = 2'h2,
    MODE_UPDN_DBL = 2'h3
  } mcp_mode_t;

  typedef enum logic [1:0] {
    TB_IDLE = 2'h0,
    TB_UP   = 2'h1,
    TB_DOWN = 2'h3,
    TB_DONE = 2'h2
  } mcp_tb_state_t;

  typedef struct packed {
    logic [2:0] high_output;
    logic [2:0] low_output;
  } mcp_pins_t;

endpackage : mcp_pkg

/* mcp_power_stage.sv */
/*
  Behavioural model of the power stage and gate drivers behind the pwm pins.
  Assumes the bench commands a trip; the fault line has a pull-up on the board.
*/
`timescale 1ns/10ps
module mcp_power_stage (
  input  wire mcp_pkg::mcp_pins_t pins,
  input  wire logic               trip,
  output logic                    fault_a_input,
  output logic                    shoot_through
);
  // ---------------------------------------------------------------
  // fault report and leg monitor
  // ---------------------------------------------------------------
  // open drain with pull-up: released line reads high, trip pulls low
  assign fault_a_input = trip ? 1'b0 : 1'b1;
  // both switches of one leg on would short the supply
  assign shoot_through = |(pins.high_output & pins.low_output);
endmodule : mcp_power_stage

/* testbench.sv */
/*
  Self-checking bench of the pwm unit: apb master, power stage model, pin counters.
  Assumes one wait state on apb and the register map of the package.
*/
`timescale 1ns/10ps
module testbench;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic               sleep_mode, idle_mode, trip, fault_a_input, shoot_through, adc_trigger, irq;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata;
  logic [3:0]         fault_hist;
  logic [32:0]        exp_q[$];
  mcp_pkg::mcp_pins_t pwm_pins;
  int                 error_cnt, total_checks, cyc, c, t, d, p, c2, c3, d2, d3;
  int                 modes[3] = '{0, 2, 3};
  integer             seed;

  mcp_pwm_unit dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fault_a_input(fault_a_input), .sleep_mode(sleep_mode), .idle_mode(idle_mode),
    .pwm_pins(pwm_pins), .adc_trigger(adc_trigger), .irq(irq));
  mcp_power_stage stage_u (.pins(pwm_pins), .trip(trip), .fault_a_input(fault_a_input),
    .shoot_through(shoot_through));

  always #4 pclk = ~pclk;

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task complete_run;
    if (error_cnt == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  task check(input logic [32:0] seen, input logic [32:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : check

  // expected response is queued; the monitor compares it when pready shows
  task apb(input logic w, input logic [11:0] a, input logic [31:0] dat, input logic [32:0] e);
    exp_q.push_back(e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= dat;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] dat);
    apb(1'b1, a, dat, 33'h0);
  endtask : wr

  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask : rd

  task count(input int n);
    c = 0;
    t = 0;
    c2 = 0;
    c3 = 0;
    repeat (n) begin
      @(posedge pclk);
      c += pwm_pins.high_output[0];
      c2 += pwm_pins.high_output[1];
      c3 += pwm_pins.high_output[2];
      t += adc_trigger;
    end
  endtask : count

  // ---------------------------------------------------------------
  // monitor and timeout
  // ---------------------------------------------------------------
  always @(posedge pclk) begin
    fault_hist <= {fault_hist[2:0], ~fault_a_input};
    if (psel && penable && pready === 1'b1) check({pslverr, prdata}, exp_q.pop_front(), "apb response");
    // forced pairs are exempt while a fault is still in the synchronizer
    if (presetn && fault_hist == 4'h0 && fault_a_input)
      check({30'h0, pwm_pins.low_output}, {30'h0, ~pwm_pins.high_output}, "pair not complementary");
    check({32'h0, shoot_through}, 33'h0, "leg shoot-through");
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      complete_run();
    end
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    seed = 32'h2ebe;
    {pclk, presetn, psel, penable, pwrite, sleep_mode, idle_mode, trip} = 8'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    fault_hist = 4'h0;
    {error_cnt, total_checks, cyc} = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(mcp_pkg::OFS_PER_BUF, 32'hffff);
    rd(mcp_pkg::OFS_DUTY1, 32'h0);
    apb(1'b0, 12'h030, 32'h0, {1'b1, 32'h0});
    d = ($random(seed) & 32'h7) + 1;
    wr(mcp_pkg::OFS_PER_BUF, 32'h9);
    wr(mcp_pkg::OFS_DUTY1, d);
    d2 = $random(seed) & 32'hf;
    d3 = $random(seed) & 32'hf;
    wr(mcp_pkg::OFS_DUTY2, d2);
    wr(mcp_pkg::OFS_DUTY3, d3);
    wr(mcp_pkg::OFS_TB_CTRL, 32'h1);
    repeat (30) @(posedge pclk);
    count(10); check(c, d, "edge-aligned duty");
    check(c2, (d2 > 10) ? 10 : d2, "duty generator two");
    check(c3, (d3 > 10) ? 10 : d3, "duty generator three");
    wr(mcp_pkg::OFS_OUT_CTL2, 32'h1);
    // 9 lies outside the random range of d, so a leaked load always shows
    wr(mcp_pkg::OFS_DUTY1, 32'h9);
    repeat (30) @(posedge pclk);
    count(10); check(c, d, "duty loaded under lockout");
    wr(mcp_pkg::OFS_OUT_CTL2, 32'h0);
    repeat (20) @(posedge pclk);
    count(10); check(c, 9, "duty not loaded after lockout");
    idle_mode <= 1'b1;
    wr(mcp_pkg::OFS_TB_CTRL, 32'h9);
    // pins lag the halted count by one register stage
    repeat (2) @(posedge pclk);
    count(20); check(c % 20, 0, "pins moved in idle halt");
    wr(mcp_pkg::OFS_TB_CTRL, 32'h1);
    repeat (10) @(posedge pclk);
    count(10); check(c, 9, "unit stopped in idle");
    idle_mode <= 1'b0;
    foreach (modes[m]) begin
      for (int s = 0; s < 16; s += 15) begin
        for (int dir = 0; dir < 2; dir++) begin
          p = (modes[m] == 0) ? 10 : 18;
          wr(mcp_pkg::OFS_OUT_CTL2, s << 1);
          wr(mcp_pkg::OFS_TB_CTRL, (modes[m] << 1) | 1);
          wr(mcp_pkg::OFS_SEV_CMP, (dir << 16) | 9);
          repeat (2 * p * (s + 1)) @(posedge pclk);
          count(3 * p * (s + 1));
          check(t, (modes[m] != 0 && dir == 1) ? 0 : 3, "trigger count");
          check(c, 3 * (s + 1) * ((modes[m] == 0) ? 9 : 17), "high time per period");
        end
      end
    end
    wr(mcp_pkg::OFS_TB_CTRL, 32'h0);
    wr(mcp_pkg::OFS_OUT_CTL2, 32'h0);
    wr(mcp_pkg::OFS_IRQ_CLR, 32'h1f);
    wr(mcp_pkg::OFS_IRQ_EN, 32'h8);
    rd(mcp_pkg::OFS_IRQ_STS, 32'h0);
    check(irq, 1'b0, "irq without event");
    wr(mcp_pkg::OFS_TB_CTRL, 32'h1);
    repeat (15) @(posedge pclk);
    check(irq, 1'b1, "special event irq");
    rd(mcp_pkg::OFS_IRQ_STS, 32'h9);
    wr(mcp_pkg::OFS_TB_CTRL, 32'h5);
    repeat (20) @(posedge pclk);
    rd(mcp_pkg::OFS_IRQ_STS, 32'hb);
    wr(mcp_pkg::OFS_IRQ_EN, 32'h0);
    repeat (3) @(posedge pclk);
    check(irq, 1'b0, "masked irq");
    rd(mcp_pkg::OFS_IRQ_CLR, 32'h0);
    wr(mcp_pkg::OFS_TB_CTRL, 32'h3);
    repeat (40) @(posedge pclk);
    rd(mcp_pkg::OFS_TB_CTRL, 32'h2);
    wr(mcp_pkg::OFS_IRQ_EN, 32'h14);
    sleep_mode <= 1'b1;
    trip <= 1'b1;
    wr(mcp_pkg::OFS_OUT_CTL2, 32'h120);
    repeat (6) @(posedge pclk);
    check({pwm_pins.high_output[0], pwm_pins.low_output[0]}, 2'b10, "fault level");
    wr(mcp_pkg::OFS_IRQ_CLR, 32'h1f);
    rd(mcp_pkg::OFS_IRQ_STS, 32'h14);
    check(irq, 1'b1, "wake irq");
    trip <= 1'b0;
    sleep_mode <= 1'b0;
    wr(mcp_pkg::OFS_OUT_CTL2, 32'h0);
    repeat (6) @(posedge pclk);
    wr(mcp_pkg::OFS_IRQ_CLR, 32'h1f);
    rd(mcp_pkg::OFS_IRQ_STS, 32'h0);
    repeat (3) @(posedge pclk);
    check(irq, 1'b0, "irq after clear");
    // reset in mid-run: pins park, buffers return to their reset values
    wr(mcp_pkg::OFS_TB_CTRL, 32'h1);
    repeat (5) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check({27'h0, pwm_pins}, {27'h0, 6'h07}, "pins during reset");
    presetn <= 1'b1;
    rd(mcp_pkg::OFS_PER_BUF, 32'hffff);
    rd(mcp_pkg::OFS_TB_CTRL, 32'h0);
    complete_run();
  end
endmodule : testbench
